// *** hdl/wit_pkg.sv ***
// constants shared by the watch and interval timer block
`default_nettype none
package wit_pkg;
  // ==========================================================
  // timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MAIN_DIV_LOG2 = 7;
  localparam int unsigned PRE_W = 9;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned IVL_MIN_LOG2 = 4;
  localparam int unsigned IVL_CODES = 6;
  localparam logic [2:0] IVL_CODE_MAX = 3'h5;

  // ==========================================================
  // register map (printed offset is an index, byte addr = 4x)
  // ==========================================================
  localparam int unsigned ADDR_W = 18;
  localparam logic [15:0] MODE_IDX = 16'hFF4A;
  localparam logic [15:0] STAT_IDX = 16'hFF4B;
  localparam logic [15:0] MASK_IDX = 16'hFF4C;

  // ==========================================================
  // mode register fields
  // ==========================================================
  localparam int unsigned MODE_SRC_BIT = 7;
  localparam int unsigned MODE_IVL_HI = 6;
  localparam int unsigned MODE_IVL_LO = 4;
  localparam int unsigned MODE_RUN_BIT = 1;
  localparam int unsigned MODE_EN_BIT = 0;
  localparam logic [7:0] MODE_WMASK = 8'hF3;
  localparam logic [7:0] MODE_RST = 8'h00;

  // ==========================================================
  // interrupt status / mask layout
  // ==========================================================
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned ST_WATCH_BIT = 0;
  localparam int unsigned ST_IVL_BIT = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;
endpackage : wit_pkg
`default_nettype wire

// *** hdl/wit_tick_gen.sv ***
// tick clock source: main clock divided by 2^7 or subsystem clock edges
`default_nettype none
module wit_tick_gen #(
  parameter int unsigned DIV_LOG2 = wit_pkg::MAIN_DIV_LOG2
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic src_sel,
  input wire logic sub_clk,
  output logic tick
);
  logic [DIV_LOG2-1:0] div_r;
  logic sub_d_r;
  wire div_wrap = &div_r;
  wire sub_rise = sub_clk & ~sub_d_r;

  // ==========================================================
  // divider and edge detect
  // ==========================================================
  // divider runs free so the main tick phase never depends on writes
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      div_r <= '0;
      sub_d_r <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 1'b1;
      sub_d_r <= sub_clk;
    end
  end

  assign tick = src_sel ? sub_rise : div_wrap;

  // ==========================================================
  // checks
  // ==========================================================
  property p_main_div;
    @(posedge ref_clk) disable iff (sys_rst)
    (!src_sel && tick) |=> (div_r == '0) ##1 (!tick || src_sel);
  endproperty
  a_main_div: assert property (p_main_div)
    else $error("main tick not on divider wrap");
endmodule : wit_tick_gen
`default_nettype wire

// *** hdl/wit_prescaler.sv ***
// 9-bit prescaler with selectable interval tap
`default_nettype none
module wit_prescaler #(
  parameter int unsigned PW = wit_pkg::PRE_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic tick,
  input wire logic [2:0] ivl_code,
  output logic [PW-1:0] pre_val,
  output logic pre_ovf,
  output logic ivl_hit
);
  logic [PW-1:0] pre_r;
  logic [wit_pkg::IVL_CODES-1:0] tap_full;

  // ==========================================================
  // one tap per legal interval code
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < wit_pkg::IVL_CODES; g++)
    begin : g_tap
      assign tap_full[g] = &pre_r[wit_pkg::IVL_MIN_LOG2+g-1:0];
    end
  endgenerate

  wire code_ok = ivl_code <= wit_pkg::IVL_CODE_MAX;
  // prohibited codes give no interval event at all
  assign ivl_hit = enable & tick & code_ok & tap_full[ivl_code];
  assign pre_ovf = enable & tick & (&pre_r);
  assign pre_val = pre_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !enable)
      pre_r <= '0;
    else if (tick)
      pre_r <= pre_r + 1'b1;
  end
endmodule : wit_prescaler
`default_nettype wire

// *** hdl/wit_top.sv ***
// watch timer with interval timer, apb register slave and interrupt
// Behaviour
// - watch and interval functions share one prescaler and run together.
// - the watch event fires every half second from a suitable tick clock.
// - mode bit 7 picks main clock / 2^7 when 0, subsystem clock when 1.
// - interval codes 0..5 give 2^4..2^9 tick periods, others are prohibited.
// - the interval event repeats at the chosen period while enabled.
// - mode bit 1 at 0 holds the 5-bit counter cleared, at 1 lets it count.
// - mode bit 0 at 0 disables and clears prescaler and counter.
// - watch counts when bits 0 and 1 are set; both clear stops and clears.
// - clearing only bit 1 restarts the watch count, prescaler kept running.
// - after enable the counter waits one prescaler cycle before counting.
// - reset loads the mode register with zero.
// - mode register takes bit and byte writes (here only byte writes, gated by pstrb[0]); bits 3 and 2 read zero.
//
// Our own choice: the APB interface to the registers.
`default_nettype none
module wit_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wit_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sub_clk,
  output logic half_second_irq,
  output logic interval_irq,
  output logic irq
);
  localparam int unsigned CW = wit_pkg::CNT_W;
  localparam int unsigned PW = wit_pkg::PRE_W;

  logic [7:0] watch_mode_reg_r;
  logic [7:0] mode_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic started_r;
  logic [wit_pkg::IRQ_W-1:0] stat_r;
  logic [wit_pkg::IRQ_W-1:0] stat_nxt;
  logic [wit_pkg::IRQ_W-1:0] mask_r;
  logic [wit_pkg::IRQ_W-1:0] mask_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;
  logic half_second_irq_r;
  logic interval_irq_r;
  logic irq_r;
  logic tick;
  logic pre_ovf;
  logic ivl_hit;
  logic [PW-1:0] pre_val;

  // ==========================================================
  // apb decode
  // ==========================================================
  wire [wit_pkg::ADDR_W-1:0] mode_addr = {wit_pkg::MODE_IDX, 2'b00};
  wire [wit_pkg::ADDR_W-1:0] stat_addr = {wit_pkg::STAT_IDX, 2'b00};
  wire [wit_pkg::ADDR_W-1:0] mask_addr = {wit_pkg::MASK_IDX, 2'b00};
  wire hit_mode = paddr == mode_addr;
  wire hit_stat = paddr == stat_addr;
  wire hit_mask = paddr == mask_addr;
  wire hit_any = hit_mode | hit_stat | hit_mask;
  // one wait state: pready rises in the second access cycle
  wire acc = psel & penable;
  wire done = acc & pready;
  wire wr_ok = done & pwrite & hit_any & pstrb[0];
  wire wr_mode = wr_ok & hit_mode;
  wire wr_stat = wr_ok & hit_stat;
  wire wr_mask = wr_ok & hit_mask;

  // ==========================================================
  // mode register
  // ==========================================================
  wire en = watch_mode_reg_r[wit_pkg::MODE_EN_BIT];
  wire run = watch_mode_reg_r[wit_pkg::MODE_RUN_BIT];
  wire src = watch_mode_reg_r[wit_pkg::MODE_SRC_BIT];
  wire [2:0] ivl_code =
    watch_mode_reg_r[wit_pkg::MODE_IVL_HI:wit_pkg::MODE_IVL_LO];

  // reserved bits 3:2 are forced to zero on every write
  assign mode_nxt = wr_mode ? (pwdata[7:0] & wit_pkg::MODE_WMASK)
                            : watch_mode_reg_r;

  // ==========================================================
  // tick source and prescaler
  // ==========================================================
  wit_tick_gen #(
    .DIV_LOG2(wit_pkg::MAIN_DIV_LOG2)
  ) u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .src_sel(src),
    .sub_clk(sub_clk),
    .tick(tick)
  );

  wit_prescaler #(
    .PW(PW)
  ) u_pre (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .enable(en),
    .tick(tick),
    .ivl_code(ivl_code),
    .pre_val(pre_val),
    .pre_ovf(pre_ovf),
    .ivl_hit(ivl_hit)
  );

  // ==========================================================
  // 5-bit watch counter
  // ==========================================================
  // the first prescaler wrap after enable only arms the counter, so the
  // first watch event comes one prescaler cycle late
  wire cnt_step = en & run & started_r & pre_ovf;
  wire watch_evt = cnt_step & (&cnt_r);
  assign cnt_nxt = (!en || !run) ? '0 :
                   cnt_step ? cnt_r + 1'b1 : cnt_r;

  // ==========================================================
  // interrupt status and mask
  // ==========================================================
  wire [wit_pkg::IRQ_W-1:0] evt = {ivl_hit, watch_evt};
  // set wins over a write-one-to-clear in the same cycle
  assign stat_nxt = (stat_r & ~(wr_stat ? pwdata[wit_pkg::IRQ_W-1:0]
                                        : '0)) | evt;
  assign mask_nxt = wr_mask ? pwdata[wit_pkg::IRQ_W-1:0] : mask_r;

  // ==========================================================
  // read path and bus answer
  // ==========================================================
  wire [31:0] rd_mux = hit_mode ? {24'h000000, watch_mode_reg_r} :
                       hit_stat ? {30'h00000000, stat_r} :
                       hit_mask ? {30'h00000000, mask_r} : 32'h00000000;
  assign pready_nxt = acc & ~pready;
  assign pslverr_nxt = acc & ~pready & ~hit_any;
  assign prdata_nxt = (acc & ~pready & ~pwrite) ? rd_mux : 32'h00000000;

  // ==========================================================
  // state
  // ==========================================================
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      watch_mode_reg_r <= wit_pkg::MODE_RST;
      cnt_r <= '0;
      started_r <= 1'b0;
      stat_r <= wit_pkg::IRQ_RST;
      mask_r <= wit_pkg::IRQ_RST;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      half_second_irq_r <= 1'b0;
      interval_irq_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      watch_mode_reg_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      // arming survives a bit-1 clear so the restart is from zero only
      started_r <= en & (started_r | pre_ovf);
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      half_second_irq_r <= watch_evt;
      interval_irq_r <= ivl_hit;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end

  assign half_second_irq = half_second_irq_r;
  assign interval_irq = interval_irq_r;
  assign irq = irq_r;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  property p_disable_clears;
    !en |=> (cnt_r == '0) && (pre_val == '0) && !started_r;
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("disable did not clear prescaler and counter");

  property p_run_clears;
    (en && !run) |=> (cnt_r == '0);
  endproperty
  a_run_clears: assert property (p_run_clears)
    else $error("counter not held cleared while stopped");

  property p_both_count;
    (en && run && started_r && pre_ovf && cnt_r != '1) |=>
      (cnt_r == $past(cnt_r) + 5'h01);
  endproperty
  a_both_count: assert property (p_both_count)
    else $error("watch counter failed to advance");

  property p_keep_pre;
    (en && !run && !wr_mode && tick) |=>
      (pre_val == $past(pre_val) + 9'h001);
  endproperty
  a_keep_pre: assert property (p_keep_pre)
    else $error("prescaler disturbed by counter stop");

  property p_first_wait;
    $rose(en) |-> !started_r && !cnt_step;
  endproperty
  a_first_wait: assert property (p_first_wait)
    else $error("counter counted before first prescaler wrap");

  property p_watch_ovf;
    half_second_irq |-> $past(cnt_r) == '1 && $past(pre_ovf)
      ##1 (cnt_r == '0 || !run);
  endproperty
  a_watch_ovf: assert property (p_watch_ovf)
    else $error("watch event not on counter overflow");

  property p_ivl_legal;
    interval_irq |-> $past(ivl_code) <= 3'h5 && $past(en) && $past(tick);
  endproperty
  a_ivl_legal: assert property (p_ivl_legal)
    else $error("interval event from prohibited code or while disabled");

  property p_ivl_tap;
    (en && tick && ivl_code == 3'h0 && pre_val[3:0] == 4'hF) |=> interval_irq;
  endproperty
  a_ivl_tap: assert property (p_ivl_tap)
    else $error("shortest interval event missing");

  property p_reserved_zero;
    watch_mode_reg_r[3:2] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved mode bits not zero");

  property p_reset_mode;
    $past(sys_rst) |-> watch_mode_reg_r == 8'h00 && !irq;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("mode register not zero after reset");

  property p_shared_chain;
    (half_second_irq && en) |-> $past(pre_val) == 9'h1FF;
  endproperty
  a_shared_chain: assert property (p_shared_chain)
    else $error("watch event not aligned to shared prescaler");

  c_watch: cover property (half_second_irq);
  c_ivl: cover property (interval_irq && run);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (pslverr);
endmodule : wit_top
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking testbench for the watch and interval timer block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, sys_rst, psel, penable, pwrite, sub_clk;
  logic [wit_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic pready, pslverr, half_second_irq, interval_irq, irq;
  logic [7:0] rd;
  logic err;
  int n_fail, compares, cyc, ivn;
  wit_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sub_clk(sub_clk), .half_second_irq(half_second_irq),
    .interval_irq(interval_irq), .irq(irq));
  // ==========================================================
  // clock, subsystem clock and closing
  // ==========================================================
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // subsystem clock toggles every cycle: one tick per two cycles
  always @(posedge ref_clk) sub_clk <= ~sub_clk;
  task automatic end_of_test();
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  // ==========================================================
  // apb master and event waits
  // ==========================================================
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd, input logic [3:0] st);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    pstrb <= st;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1, "pready");
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // counts cycles up to the next pulse, and interval pulses on the way
  task automatic wait_irq(input bit watch, input int lim);
    cyc = 0;
    ivn = 0;
    do
    begin
      @(posedge ref_clk);
      cyc++;
      if (interval_irq === 1'b1)
        ivn++;
    end
    while (!((watch ? half_second_irq : interval_irq) === 1'b1) &&
           cyc < lim);
  endtask : wait_irq
  function automatic logic [7:0] mode_of(input logic src,
    input logic [2:0] code, input logic run, input logic en);
    return {src, code, 2'b00, run, en};
  endfunction : mode_of
  initial
  begin
    repeat (95000) @(posedge ref_clk);
    n_fail++;
    $display("unexpected %0t watchdog expired", $time);
    end_of_test();
  end
  // ==========================================================
  // tests
  // ==========================================================
  initial
  begin
    n_fail = 0;
    compares = 0;
    sys_rst = 1'b1;
    sub_clk = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, wit_pkg::MODE_IDX, 8'h00, 4'h0);
    chk(rd, 8'h00, "mode reset");
    chk({31'h0, err}, 32'h0, "mapped no error");
    apb(1'b0, wit_pkg::MASK_IDX, 8'h00, 4'h0);
    chk(rd, 8'h00, "mask reset");
    apb(1'b1, wit_pkg::MODE_IDX, 8'hFC, 4'h1);
    apb(1'b0, wit_pkg::MODE_IDX, 8'h00, 4'h0);
    chk(rd, 8'hF0, "mode bits 3:2");
    apb(1'b1, wit_pkg::MODE_IDX, 8'h00, 4'h0);
    apb(1'b0, wit_pkg::MODE_IDX, 8'h00, 4'h0);
    chk(rd, 8'hF0, "strobe off write");
    apb(1'b1, 16'h0123, 8'h55, 4'h1);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, wit_pkg::MODE_IDX, 8'h00, 4'h1);
    // every legal interval code, subsystem clock as tick source
    for (int c = 0; c < 6; c++)
    begin
      apb(1'b1, wit_pkg::MODE_IDX, mode_of(1'b1, c[2:0], 1'b0, 1'b1), 4'h1);
      // skip a pulse of the old code launched at the write edge
      @(posedge ref_clk);
      wait_irq(1'b0, 4000);
      wait_irq(1'b0, 4000);
      chk(cyc, 2 << (c + 4), "interval period");
      wait_irq(1'b0, 4000);
      chk(cyc, 2 << (c + 4), "interval repeat");
    end
    wait_irq(1'b0, 10);
    apb(1'b1, wit_pkg::MODE_IDX, mode_of(1'b1, 3'h0, 1'b0, 1'b0), 4'h1);
    wait_irq(1'b0, 200);
    chk(cyc, 200, "no interval when disabled");
    apb(1'b0, wit_pkg::STAT_IDX, 8'h00, 4'h0);
    chk(rd, 8'h02, "status after intervals");
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, wit_pkg::MASK_IDX, 8'h03, 4'h1);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    apb(1'b1, wit_pkg::STAT_IDX, 8'h02, 4'h1);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    apb(1'b1, wit_pkg::MODE_IDX, mode_of(1'b1, 3'h6, 1'b0, 1'b1), 4'h1);
    wait_irq(1'b0, 2500);
    chk(cyc, 2500, "prohibited code silent");
    // divided main clock: 2^4 ticks of 128 cycles
    apb(1'b1, wit_pkg::MODE_IDX, mode_of(1'b0, 3'h0, 1'b0, 1'b1), 4'h1);
    wait_irq(1'b0, 5000);
    wait_irq(1'b0, 5000);
    chk(cyc, 2048, "main clock interval");
    // watch from a cleared chain: first event one prescaler cycle late
    apb(1'b1, wit_pkg::MODE_IDX, 8'h00, 4'h1);
    apb(1'b1, wit_pkg::MODE_IDX, mode_of(1'b1, 3'h5, 1'b1, 1'b1), 4'h1);
    wait_irq(1'b1, 40000);
    chk((cyc > 33786 && cyc < 33798), 1, "first watch event");
    wait_irq(1'b1, 40000);
    chk(cyc, 32768, "watch period");
    chk(ivn, 32, "interval during watch");
    apb(1'b0, wit_pkg::STAT_IDX, 8'h00, 4'h0);
    chk(rd, 8'h03, "status both events");
    chk({31'h0, irq}, 32'h1, "irq pending");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
